// [interrupt_vector_priority.v]
// Contract
// - twenty sources: one nmi, eighteen maskable, break
// - simultaneous maskable requests: lowest level number wins
// - watchdog nmi mode overflow vectors 0004H unmasked
// - watchdog interval mode overflow: maskable level 0
// - van requests levels 1-3, vectors 0006H-000AH
// - external edge requests levels 4-6, 000CH-0010H
// - timer16 first request: match0 or capture1 edge
// - timer16 second request: match1 or capture0 edge
// - 8-bit timer matches at levels 9 and 10
// - watch interval level 11, watch tick 12
// - clocked serial done level 13, 001EH
// - async receive error level 14, 0020H
// - async receive done level 15, 0022H
// - tx done level 16; adc done level 17
// - break instruction: unmaskable, vector 003EH
// - pin or watchdog runaway reset fetches 0000H
// - external pins: rising, falling or both edges
`timescale 1ns/1ps
`include "int_vector_consts.vh"

module interrupt_vector_priority #(
    parameter N_MASK = `NUM_MASKABLE    // maskable request lines
) (
    input wire clk_sys_i,                // system clock, 100 MHz
    input wire rst_i,                    // synchronous reset, high
    input wire ext_reset_pin_i,          // reset pin level, async
    input wire wdt_runaway_i,            // watchdog runaway pulse
    input wire wdt_nmi_mode_i,           // 1: watchdog as nmi
    input wire watchdog_overflow_req_i,  // watchdog overflow pulse
    input wire van_end_of_message_req_i, // van event pulse
    input wire van_emission_req_i,       // van event pulse
    input wire van_reception_req_i,      // van event pulse
    input wire [2:0] ext_pin_i,          // external pins, async
    input wire [5:0] ext_edge_sel_i,     // two bits per pin
    input wire timer16_capture_mode_i,   // 1: capture, 0: compare
    input wire timer16_match0_i,         // counter hit compare zero
    input wire timer16_match1_i,         // counter hit compare one
    input wire timer16_cap_edge0_i,      // capture input zero edge
    input wire timer16_cap_edge1_i,      // capture input one edge
    input wire timer8a_match_req_i,      // 8-bit timer a match
    input wire timer8b_match_req_i,      // 8-bit timer b match
    input wire watch_interval_req_i,     // watch timer interval
    input wire watch_tick_req_i,         // watch tick
    input wire clocked_serial_done_req_i, // serial transfer done
    input wire async_rx_error_req_i,     // receive error
    input wire async_rx_done_req_i,      // receive complete
    input wire async_tx_done_req_i,      // transmit complete
    input wire adc_done_req_i,           // conversion end
    input wire software_break_instruction_i, // break executed
    input wire [N_MASK-1:0] mask_i,      // 1 masks that source
    input wire int_enable_i,             // cpu maskable enable
    input wire ack_i,                    // cpu takes the offer
    output wire int_req_o,               // offer pending, level
    output reg [15:0] vector_o,          // vector code address
    output reg [1:0] kind_o,             // reset, nmi, brk, mask
    output reg [4:0] src_o,              // maskable source index
    output wire [N_MASK-1:0] pend_o      // pending maskable flags
);

// ==========================================================
// state encoding, one-hot
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_OFFER = 3'h2;
localparam [2:0] ST_SETTLE = 3'h4;

reg [2:0] state_r;
reg [2:0] state_nxt;

reg [N_MASK-1:0] flag_r;
reg [N_MASK-1:0] flag_nxt;
reg nmi_r;
reg brk_r;
reg rst_pend_r;
reg rpin_meta_r;
reg rpin_sync_r;
reg rpin_last_r;
// winner of the pick, latched while idle
reg [15:0] vector_nxt;
reg [1:0] kind_nxt;
reg [4:0] src_nxt;

wire [2:0] ext_edge;
wire [N_MASK-1:0] set_vec;
wire [N_MASK-1:0] eligible;
wire mask_found;
wire [4:0] mask_idx;
wire took;
wire clr_mask;
wire reset_event;
// decoded state and accept terms
wire in_idle;
wire in_offer;
wire any_pending;
wire took_rst;
wire took_nmi;
wire took_brk;

// ==========================================================
// vector for a maskable index; level 0 shares the nmi slot
function [15:0] mask_vector;
    input [4:0] idx;
    begin
        if (idx == `SRC_WDT) begin
            mask_vector = `VEC_WDT_MASK;
        end else begin
            mask_vector = `VEC_MASK_BASE +
                ({11'h000, idx - 5'h01} * `VEC_MASK_STEP);
        end
    end
endfunction

// ==========================================================
// accept decode, shared by every pending source kind
function taken_as;
    input offer_taken;
    input [1:0] kind_now;
    input [1:0] kind_want;
    begin
        taken_as = offer_taken & (kind_now == kind_want);
    end
endfunction

// ==========================================================
// external edge detectors, one per pin
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : ext_gen
        ext_edge_detect u_edge (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .pin_i(ext_pin_i[g]),
            .sel_i(ext_edge_sel_i[2*g+1:2*g]),
            .edge_o(ext_edge[g])
        );
    end
endgenerate

// ==========================================================
// source map: bit position is the default priority level
assign set_vec[`SRC_WDT] =
    watchdog_overflow_req_i & ~wdt_nmi_mode_i;
assign set_vec[`SRC_VAN_EOM] = van_end_of_message_req_i;
assign set_vec[`SRC_VAN_EMIT] = van_emission_req_i;
assign set_vec[`SRC_VAN_RECV] = van_reception_req_i;
assign set_vec[`SRC_EXT0] = ext_edge[0];
assign set_vec[`SRC_EXT1] = ext_edge[1];
assign set_vec[`SRC_EXT2] = ext_edge[2];
assign set_vec[`SRC_TM16_0] = timer16_capture_mode_i ?
    timer16_cap_edge1_i : timer16_match0_i;
assign set_vec[`SRC_TM16_1] = timer16_capture_mode_i ?
    timer16_cap_edge0_i : timer16_match1_i;
assign set_vec[`SRC_TM8A] = timer8a_match_req_i;
assign set_vec[`SRC_TM8B] = timer8b_match_req_i;
assign set_vec[`SRC_WATCH_INT] = watch_interval_req_i;
assign set_vec[`SRC_WATCH_TICK] = watch_tick_req_i;
assign set_vec[`SRC_CSI_DONE] = clocked_serial_done_req_i;
assign set_vec[`SRC_RX_ERR] = async_rx_error_req_i;
assign set_vec[`SRC_RX_DONE] = async_rx_done_req_i;
assign set_vec[`SRC_TX_DONE] = async_tx_done_req_i;
assign set_vec[`SRC_ADC_DONE] = adc_done_req_i;

// ==========================================================
// eligibility: masked flags are held, just not offered
assign eligible = flag_r & ~mask_i & {N_MASK{int_enable_i}};

prio_pick #(
    .N(N_MASK),
    .W(5)
) u_pick (
    .req_i(eligible),
    .found_o(mask_found),
    .idx_o(mask_idx)
);

// ==========================================================
// state decode, named once so every user agrees
assign in_idle = (state_r == ST_IDLE);
assign in_offer = (state_r == ST_OFFER);

// ==========================================================
// handshake terms; an ack outside an offer is ignored
assign took = in_offer & ack_i;
assign clr_mask = taken_as(took, kind_o, `KIND_MASK);
assign took_rst = taken_as(took, kind_o, `KIND_RESET);
assign took_nmi = taken_as(took, kind_o, `KIND_NMI);
assign took_brk = taken_as(took, kind_o, `KIND_BRK);
assign int_req_o = in_offer;
assign pend_o = flag_r;

// anything waiting that the cpu may be offered now
assign any_pending = rst_pend_r | nmi_r | brk_r | mask_found;

// ==========================================================
// reset pin synchroniser; only rpin_sync_r reads the first stage
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        rpin_meta_r <= 1'b0;
        rpin_sync_r <= 1'b0;
        rpin_last_r <= 1'b0;
    end else begin
        rpin_meta_r <= ext_reset_pin_i;
        rpin_sync_r <= rpin_meta_r;
        rpin_last_r <= rpin_sync_r;
    end
end

// a pin assertion or watchdog runaway both restart at 0000H
assign reset_event = (rpin_sync_r & ~rpin_last_r) | wdt_runaway_i;

// ==========================================================
// maskable flags: a set in the clear cycle wins
// so an event in the accept cycle is offered again
always @* begin
    flag_nxt = flag_r;
    if (clr_mask) begin
        flag_nxt[src_o] = 1'b0;
    end
    flag_nxt = flag_nxt | set_vec;
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        flag_r <= {N_MASK{1'b0}};
    end else begin
        flag_r <= flag_nxt;
    end
end

// ==========================================================
// unmaskable flags: nmi, break and reset fetch
// in each, a new event beats the clear of the old one, so
// a request landing in the accept cycle is never lost

// watchdog overflow in nmi mode ignores masks and enable
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        nmi_r <= 1'b0;
    end else if (watchdog_overflow_req_i & wdt_nmi_mode_i) begin
        nmi_r <= 1'b1;
    end else if (took_nmi) begin
        nmi_r <= 1'b0;
    end
end

// break instruction, unmaskable as well
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        brk_r <= 1'b0;
    end else if (software_break_instruction_i) begin
        brk_r <= 1'b1;
    end else if (took_brk) begin
        brk_r <= 1'b0;
    end
end

// system reset leaves a reset fetch pending so the cpu
// starts from the reset vector
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        rst_pend_r <= 1'b1;
    end else if (reset_event) begin
        rst_pend_r <= 1'b1;
    end else if (took_rst) begin
        rst_pend_r <= 1'b0;
    end
end

// ==========================================================
// offer sequencer; settle lets a cleared flag drop before
// the next pick, at the cost of one idle cycle per accept
// idle: pick and latch the winner
// offer: int_req_o high, outputs stand until ack
// settle: one dead cycle, then idle picks again
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_IDLE: begin
            if (any_pending) begin
                state_nxt = ST_OFFER;
            end
        end
        ST_OFFER: begin
            if (ack_i) begin
                state_nxt = ST_SETTLE;
            end
        end
        ST_SETTLE: begin
            state_nxt = ST_IDLE;
        end
        default: begin
            state_nxt = ST_IDLE;
        end
    endcase
end

always @(posedge clk_sys_i) begin
    if (rst_i) begin
        state_r <= ST_IDLE;
    end else begin
        state_r <= state_nxt;
    end
end

// ==========================================================
// winner: reset, then nmi, then break, then maskable
// holds the old offer when nothing is pending
always @* begin
    vector_nxt = vector_o;
    kind_nxt = kind_o;
    src_nxt = src_o;
    if (rst_pend_r) begin
        vector_nxt = `VEC_RESET;
        kind_nxt = `KIND_RESET;
    end else if (nmi_r) begin
        vector_nxt = `VEC_NMI;
        kind_nxt = `KIND_NMI;
    end else if (brk_r) begin
        vector_nxt = `VEC_BRK;
        kind_nxt = `KIND_BRK;
    end else if (mask_found) begin
        vector_nxt = mask_vector(mask_idx);
        kind_nxt = `KIND_MASK;
        src_nxt = mask_idx;
    end
end

// ==========================================================
// latch the winner only in idle: the offer is frozen once
// made, so a later higher request waits for the next pick;
// the cost is that a late nmi sits behind a slow accept
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        vector_o <= `VEC_RESET;
        kind_o <= `KIND_RESET;
        src_o <= 5'h00;
    end else if (in_idle) begin
        vector_o <= vector_nxt;
        kind_o <= kind_nxt;
        src_o <= src_nxt;
    end
end

endmodule // interrupt_vector_priority

// [int_vector_consts.vh]
`ifndef INT_VECTOR_CONSTS_VH
`define INT_VECTOR_CONSTS_VH

// ==========================================================
// vector code addresses
`define VEC_RESET      16'h0000
`define VEC_NMI        16'h0004
`define VEC_WDT_MASK   16'h0004
`define VEC_MASK_BASE  16'h0006
`define VEC_MASK_STEP  16'h0002
`define VEC_BRK        16'h003E

// ==========================================================
// maskable source positions, index equals default priority
`define SRC_WDT        5'h00
`define SRC_VAN_EOM    5'h01
`define SRC_VAN_EMIT   5'h02
`define SRC_VAN_RECV   5'h03
`define SRC_EXT0       5'h04
`define SRC_EXT1       5'h05
`define SRC_EXT2       5'h06
`define SRC_TM16_0     5'h07
`define SRC_TM16_1     5'h08
`define SRC_TM8A       5'h09
`define SRC_TM8B       5'h0A
`define SRC_WATCH_INT  5'h0B
`define SRC_WATCH_TICK 5'h0C
`define SRC_CSI_DONE   5'h0D
`define SRC_RX_ERR     5'h0E
`define SRC_RX_DONE    5'h0F
`define SRC_TX_DONE    5'h10
`define SRC_ADC_DONE   5'h11
`define NUM_MASKABLE   18

// ==========================================================
// grant kinds
`define KIND_RESET     2'h0
`define KIND_NMI       2'h1
`define KIND_BRK       2'h2
`define KIND_MASK      2'h3

// ==========================================================
// edge select codes per external pin
`define EDGE_NONE      2'h0
`define EDGE_RISE      2'h1
`define EDGE_FALL      2'h2
`define EDGE_BOTH      2'h3

`endif

// [ext_edge_detect.v]
`timescale 1ns/1ps
`include "int_vector_consts.vh"

module ext_edge_detect (
    input wire clk_sys_i,      // system clock
    input wire rst_i,          // synchronous reset, active high
    input wire pin_i,          // asynchronous pin level
    input wire [1:0] sel_i,    // valid edge selection
    output reg edge_o          // one-cycle pulse on valid edge
);

reg meta_r;
reg sync_r;
reg last_r;
wire rise;
wire fall;

// ==========================================================
// synchroniser: only sync_r reads meta_r
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        last_r <= 1'b0;
    end else begin
        meta_r <= pin_i;
        sync_r <= meta_r;
        last_r <= sync_r;
    end
end

assign rise = sync_r & ~last_r;
assign fall = ~sync_r & last_r;

// ==========================================================
// edge qualification by selected mode
always @(posedge clk_sys_i) begin
    if (rst_i) begin
        edge_o <= 1'b0;
    end else begin
        case (sel_i)
            `EDGE_RISE: edge_o <= rise;
            `EDGE_FALL: edge_o <= fall;
            `EDGE_BOTH: edge_o <= rise | fall;
            default: edge_o <= 1'b0;
        endcase
    end
end

endmodule // ext_edge_detect

// [prio_pick.v]
`timescale 1ns/1ps

module prio_pick #(
    parameter N = 18,          // number of request lines
    parameter W = 5            // index width
) (
    input wire [N-1:0] req_i,  // eligible requests
    output reg found_o,        // any request present
    output reg [W-1:0] idx_o   // lowest index, highest priority
);

integer i;

// ==========================================================
// scan from the lowest rank upward so index 0 wins last
always @* begin
    found_o = 1'b0;
    idx_o = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
        if (req_i[i]) begin
            found_o = 1'b1;
            idx_o = i[W-1:0];
        end
    end
end

endmodule // prio_pick

// [ivp_props.sv]
`timescale 1ns/1ps
`include "int_vector_consts.vh"

// ==========================================================
// offer handshake and vector checks
module ivp_props #(
    parameter N_MASK = 18 // maskable lines
) (
    input logic clk_sys_i, // clock
    input logic rst_i, // reset
    input logic ack_i, // accept
    input logic [N_MASK-1:0] mask_i, // masks
    input logic int_req_o, // offer
    input logic [15:0] vector_o, // vector
    input logic [1:0] kind_o, // kind
    input logic [4:0] src_o, // source
    input logic [N_MASK-1:0] pend_o // flags
);
    logic [N_MASK-1:0] below;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // flags that outrank the offered source
    assign below = N_MASK'((32'h1 << src_o) - 32'h1);

    // settle then pick: no offer for two cycles after an accept
    sequence s_quiet;
        !int_req_o [*2];
    endsequence
    property p_gap;
        int_req_o && ack_i |=> s_quiet;
    endproperty
    a_gap: assert property (p_gap) else $error("offer too soon");

    property p_stand;
        int_req_o && !ack_i
            |=> int_req_o && $stable({vector_o, kind_o, src_o});
    endproperty
    a_stand: assert property (p_stand) else $error("offer moved");

    property p_reset_vec;
        int_req_o && kind_o == `KIND_RESET |-> vector_o == `VEC_RESET;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vec");

    property p_nmi_vec;
        int_req_o && kind_o == `KIND_NMI |-> vector_o == `VEC_NMI;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vec");

    property p_brk_vec;
        int_req_o && kind_o == `KIND_BRK |-> vector_o == `VEC_BRK;
    endproperty
    a_brk_vec: assert property (p_brk_vec) else $error("break vec");

    // level 0 shares 0004H, the rest step by two from 0006H
    property p_mask_vec;
        int_req_o && kind_o == `KIND_MASK
            |-> vector_o == 16'h0004 + {10'h000, src_o, 1'b0}
                && src_o < N_MASK;
    endproperty
    a_mask_vec: assert property (p_mask_vec) else $error("mask vec");

    property p_no_drop;
        !ack_i |=> ($past(pend_o) & ~pend_o) == '0;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("flag lost");

    property p_prio;
        $rose(int_req_o) && kind_o == `KIND_MASK
            |-> ($past(pend_o) & ~$past(mask_i) & below) == '0;
    endproperty
    a_prio: assert property (p_prio) else $error("low level won");
endmodule // ivp_props

// [cpu_ack_model.sv]
`timescale 1ns/1ps

// ==========================================================
// cpu side: accepts each offer after a set wait
module cpu_ack_model (
    input wire clk_sys_i, // clock
    input wire rst_i, // reset
    input wire int_req_i, // offer
    input wire [3:0] dly_i, // wait cycles
    output reg ack_o // one-cycle accept
);
    reg [3:0] cnt_r;

    // falling edge, so the accept is settled at the sampling edge
    always @(negedge clk_sys_i) begin
        if (rst_i || !int_req_i || ack_o) begin
            ack_o <= 1'b0;
            cnt_r <= 4'h0;
        end else if (cnt_r >= dly_i) begin
            ack_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
endmodule // cpu_ack_model

// [tb.sv]
`timescale 1ns/1ps
`include "int_vector_consts.vh"

// ==========================================================
// top bench
module tb;
    reg clk_sys_i, rst_i, pin_rst, runaway, nmi_mode, software_break_instruction, cap_mode, ien;
    reg [17:0] ev, mask;
    reg [3:0] t16, ack_dly;
    reg [2:0] pin;
    reg [5:0] esel;
    wire int_req_o, ack;
    wire [15:0] vector_o;
    wire [1:0] kind_o;
    wire [4:0] src_o;
    wire [17:0] pend_o;
    integer err_count, n_compared, cyc;

    interrupt_vector_priority i_interrupt_vector_priority (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ext_reset_pin_i(pin_rst),
        .wdt_runaway_i(runaway), .wdt_nmi_mode_i(nmi_mode),
        .watchdog_overflow_req_i(ev[0]), .van_end_of_message_req_i(ev[1]),
        .van_emission_req_i(ev[2]), .van_reception_req_i(ev[3]),
        .ext_pin_i(pin), .ext_edge_sel_i(esel),
        .timer16_capture_mode_i(cap_mode), .timer16_match0_i(t16[0]),
        .timer16_match1_i(t16[1]), .timer16_cap_edge0_i(t16[2]),
        .timer16_cap_edge1_i(t16[3]), .timer8a_match_req_i(ev[9]),
        .timer8b_match_req_i(ev[10]), .watch_interval_req_i(ev[11]),
        .watch_tick_req_i(ev[12]), .clocked_serial_done_req_i(ev[13]),
        .async_rx_error_req_i(ev[14]), .async_rx_done_req_i(ev[15]),
        .async_tx_done_req_i(ev[16]), .adc_done_req_i(ev[17]),
        .software_break_instruction_i(software_break_instruction), .mask_i(mask),
        .int_enable_i(ien), .ack_i(ack), .int_req_o(int_req_o),
        .vector_o(vector_o), .kind_o(kind_o), .src_o(src_o), .pend_o(pend_o)
    );

    cpu_ack_model u_cpu (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .int_req_i(int_req_o),
        .dly_i(ack_dly), .ack_o(ack)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            test_done;
        end
    end

    task check(input logic [31:0] s, input logic [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (s !== e) begin
                $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
                err_count = err_count + 1;
            end
        end
    endtask

    // level 0 shares 0004H, the others step by two from 0006H
    function [15:0] mvec(input integer k);
        mvec = (k == 0) ? 16'h0004 : 16'(16'h0006 + 2 * (k - 1));
    endfunction

    task pulse(input [17:0] v, input [3:0] t, input b);
        begin
            @(negedge clk_sys_i) {ev, t16, software_break_instruction} = {v, t, b};
            @(negedge clk_sys_i) {ev, t16, software_break_instruction} = 23'h000000;
        end
    endtask

    task expect_offer(input [1:0] k, input [15:0] v, input [4:0] s);
        integer i;
        begin
            for (i = 0; i < 40 && int_req_o !== 1'b1; i = i + 1)
                @(negedge clk_sys_i);
            check(int_req_o, 1);
            check(kind_o, k);
            check(vector_o, v);
            if (k == `KIND_MASK)
                check(src_o, s);
            for (i = 0; i < 40 && int_req_o === 1'b1; i = i + 1)
                @(negedge clk_sys_i);
        end
    endtask

    task quiet;
        integer i, hits;
        begin
            hits = 0;
            for (i = 0; i < 12; i = i + 1) begin
                @(negedge clk_sys_i);
                if (int_req_o !== 1'b0)
                    hits = hits + 1;
            end
            check(hits, 0);
        end
    endtask

    task t_reset;
        begin
            expect_offer(`KIND_RESET, `VEC_RESET, 5'h00);
            runaway = 1'b1;
            @(negedge clk_sys_i) runaway = 1'b0;
            expect_offer(`KIND_RESET, `VEC_RESET, 5'h00);
            pin_rst = 1'b1;
            expect_offer(`KIND_RESET, `VEC_RESET, 5'h00);
            pin_rst = 1'b0;
            $display("done: reset fetch");
        end
    endtask

    task t_single;
        integer k;
        begin
            for (k = 0; k < 18; k = k + 1) begin
                if (k < 4 || k > 8) begin
                    ack_dly = 4'(k % 4 * 3); // prompt and slow accepts
                    pulse(18'h00001 << k, 4'h0, 1'b0);
                    expect_offer(`KIND_MASK, mvec(k), 5'(k));
                end
            end
            ack_dly = 4'h0;
            $display("done: single sources");
        end
    endtask

    // each line in both timer modes; the unused pair must stay silent
    task t_timer16;
        integer i, e;
        begin
            for (i = 0; i < 8; i = i + 1) begin
                cap_mode = i[2];
                e = i[2] ? (i[1:0] == 3 ? 7 : i[1:0] == 2 ? 8 : 0)
                          : (i[1:0] == 0 ? 7 : i[1:0] == 1 ? 8 : 0);
                pulse(18'h00000, 4'h1 << i[1:0], 1'b0);
                if (e != 0)
                    expect_offer(`KIND_MASK, mvec(e), 5'(e));
                else
                    quiet;
            end
            $display("done: timer16 modes");
        end
    endtask

    task t_ext;
        integer g, s;
        begin
            for (g = 0; g < 3; g = g + 1) begin
                for (s = 0; s < 4; s = s + 1) begin
                    esel = 6'(s << (2 * g));
                    @(negedge clk_sys_i) pin[g] = 1'b1;
                    if (s[0])
                        expect_offer(`KIND_MASK, mvec(4 + g), 5'(4 + g));
                    else
                        quiet;
                    pin[g] = 1'b0;
                    if (s[1])
                        expect_offer(`KIND_MASK, mvec(4 + g), 5'(4 + g));
                    else
                        quiet;
                end
            end
            $display("done: external edges");
        end
    endtask

    // all but levels 4-8 at once: nmi, break, then levels in order
    task t_prio;
        integer k;
        begin
            nmi_mode = 1'b1;
            pulse(18'h3FE0F, 4'h0, 1'b1);
            expect_offer(`KIND_NMI, `VEC_NMI, 5'h00);
            expect_offer(`KIND_BRK, `VEC_BRK, 5'h00);
            for (k = 1; k < 18; k = k + 1)
                if (k < 4 || k > 8)
                    expect_offer(`KIND_MASK, mvec(k), 5'(k));
            quiet;
            nmi_mode = 1'b0;
            $display("done: priority");
        end
    endtask

    task t_mask;
        begin
            mask = 18'h20000;
            pulse(18'h30000, 4'h0, 1'b0);
            expect_offer(`KIND_MASK, mvec(16), 5'h10);
            quiet;
            check(pend_o[17], 1);
            ien = 1'b0;
            mask = 18'h00000;
            quiet;
            ien = 1'b1;
            expect_offer(`KIND_MASK, mvec(17), 5'h11);
            $display("done: masking");
        end
    endtask

    task test_done;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_count);
            if (err_count == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    initial begin
        {err_count, n_compared, cyc} = 96'h0;
        {rst_i, pin_rst, runaway, nmi_mode, software_break_instruction, cap_mode, ien} = 7'h41;
        {ev, mask, t16, ack_dly, pin, esel} = 53'h0;
        repeat (20) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rst_i = 1'b0;
        t_reset;
        t_single;
        t_timer16;
        t_ext;
        t_prio;
        t_mask;
        test_done;
    end
endmodule // tb

bind interrupt_vector_priority ivp_props #(.N_MASK(N_MASK)) i_props (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ack_i(ack_i), .mask_i(mask_i),
    .int_req_o(int_req_o), .vector_o(vector_o), .kind_o(kind_o),
    .src_o(src_o), .pend_o(pend_o)
);
